// [csr_sleep_ctrl.v]
// Overview of operation
// - enable bit one asserts peripheral sleep request
// - enable bit zero keeps sleep request low
// - counters at 31,30; register bank at 29
// - pulse outputs at 22,21,20 and 4
// - fan monitor 2 (bit 11 not in implemented mask); bus controller 10
// - watchdog 9, processor 8, trace 7, dma 6
// - power controller 5, interrupt aggregator 0
// - vendor bit 1 read/write, status reads zero
// - all enables clear on main rail reset
// - status bits mirror peripheral clock requests
// - status bits share enable bit positions
// - processor status resets one, others zero
// - auto-reload counter holds clock request high
// - system sleeps when all enabled, none requesting
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.vh"
module csr_sleep_ctrl
(
	// clock and reset
	input wire clk,
	input wire srst,
	// avalon-mm slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// peripheral sleep interface
	output reg [31:0] sleep_req,
	input wire [31:0] clk_req_in,
	// system sleep qualifier
	output reg all_asleep
);
	reg [31:0] sleep_en;
	wire [31:0] clk_req_sync;
	wire acc_rd;
	wire acc_wr;
	wire [31:0] be_mask;
	wire [31:0] clk_sts;
	reg [31:0] next_readdata;

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	csr_avs u_avs
	(
		.clk(clk),
		.srst(srst),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_waitrequest(avs_waitrequest),
		.acc_rd(acc_rd),
		.acc_wr(acc_wr)
	);

	// ----------------------------------------
	// clock request capture
	// ----------------------------------------
	csr_sync u_sync
	(
		.clk(clk),
		.srst(srst),
		.async_in(clk_req_in),
		.rst_val(`CSR_RST_CLK_REQ_STS),
		.sync_out(clk_req_sync)
	);

	// status view: reserved and vendor bits forced to zero
	assign clk_sts = clk_req_sync & `CSR_IMPL_MASK & ~(32'h1 << `CSR_BIT_VENDOR);

	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// sleep enable register, byte-lane writes, implemented bits only
	always @(posedge clk)
	begin
		if (srst)
			sleep_en <= `CSR_RST_SLEEP_EN;
		else if (acc_wr && avs_address == `CSR_OFS_SLEEP_EN)
			sleep_en <= ((avs_writedata & be_mask) | (sleep_en & ~be_mask)) & `CSR_IMPL_MASK;
	end

	// sleep requests follow enable bits one cycle later
	always @(posedge clk)
	begin
		if (srst)
			sleep_req <= 32'h00000000;
		else
			sleep_req <= sleep_en;
	end

	// system may sleep only when every block enabled and none requests clocks
	always @(posedge clk)
	begin
		if (srst)
			all_asleep <= 1'b0;
		else
			all_asleep <= (sleep_en == `CSR_IMPL_MASK) && (clk_sts == 32'h00000000);
	end

	// read mux; unmapped reads return zero
	always @*
	begin
		next_readdata = 32'h00000000;
		case (avs_address)
			`CSR_OFS_SLEEP_EN: next_readdata = sleep_en;
			`CSR_OFS_CLK_REQ_STS: next_readdata = clk_sts;
			default: next_readdata = 32'h00000000;
		endcase
	end

	always @(posedge clk)
	begin
		if (srst)
			avs_readdata <= 32'h00000000;
		else if (avs_read & avs_waitrequest)
			avs_readdata <= next_readdata;
	end
endmodule // csr_sleep_ctrl
`default_nettype wire

// [csr_map.vh]
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
// register byte offsets
`define CSR_OFS_SLEEP_EN 4'h8
`define CSR_OFS_CLK_REQ_STS 4'hC
`define CSR_OFS_ALL_SLEEP 4'h0
// implemented bits (read/write sleep enables and matching status bits)
`define CSR_IMPL_MASK 32'hE07007F7
// individual bit positions
`define CSR_BIT_CNT16_1 31
`define CSR_BIT_CNT16_0 30
`define CSR_BIT_REG_BANK 29
`define CSR_BIT_PWO_3 22
`define CSR_BIT_PWO_2 21
`define CSR_BIT_PWO_1 20
`define CSR_BIT_FSM_1 11
`define CSR_BIT_SMB_0 10
`define CSR_BIT_WATCHDOG 9
`define CSR_BIT_PROCESSOR 8
`define CSR_BIT_TRACE 7
`define CSR_BIT_DMA 6
`define CSR_BIT_PMC 5
`define CSR_BIT_PWO_0 4
`define CSR_BIT_FSM_0 2
`define CSR_BIT_VENDOR 1
`define CSR_BIT_INT_AGG 0
// reset values
`define CSR_RST_SLEEP_EN 32'h00000000
`define CSR_RST_CLK_REQ_STS 32'h00000100
`endif

// [csr_sync.v]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------
module csr_sync
(
	// clock and reset
	input wire clk,
	input wire srst,
	// async in, sync out
	input wire [31:0] async_in,
	input wire [31:0] rst_val,
	output reg [31:0] sync_out
);
	reg [31:0] meta;
	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1)
		begin : g_bit
			// first flop feeds only the second
			always @(posedge clk)
			begin
				if (srst)
				begin
					meta[i] <= rst_val[i];
					sync_out[i] <= rst_val[i];
				end
				else
				begin
					meta[i] <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule // csr_sync
`default_nettype wire

// [csr_avs.v]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// avalon-mm slave front end, one wait cycle
// ----------------------------------------
module csr_avs
(
	// clock and reset
	input wire clk,
	input wire srst,
	// avalon side
	input wire avs_read,
	input wire avs_write,
	output wire avs_waitrequest,
	// access strobes
	output wire acc_rd,
	output wire acc_wr
);
	reg done;
	// done pulses one cycle after a request is seen, releasing waitrequest
	always @(posedge clk)
	begin
		if (srst)
			done <= 1'b0;
		else
			done <= (avs_read | avs_write) & ~done;
	end
	assign avs_waitrequest = (avs_read | avs_write) & ~done;
	assign acc_rd = avs_read & done;
	assign acc_wr = avs_write & done;
endmodule // csr_avs
`default_nettype wire

// [csr_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.vh"
module csr_chk (
	// bus and handshake
	input wire logic clk, srst, avs_read, avs_write, avs_waitrequest, all_asleep,
	input wire logic [3:0] avs_address, avs_byteenable,
	input wire logic [31:0] avs_writedata, avs_readdata, sleep_req, clk_req_in
);
	localparam M = `CSR_IMPL_MASK;
	// completed transfers
	wire wr = avs_write & !avs_waitrequest;
	wire rd = avs_read & !avs_waitrequest;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// enable register updates at the write edge, the request one edge later
	a_sleep_set: assert property (wr && avs_address == 4'h8 && avs_byteenable == 4'hF |-> ##2 sleep_req == (M & $past(avs_writedata, 2))) else $error("sleep set");
	a_sleep_hold: assert property (!(wr && avs_address == 4'h8) |-> ##2 $stable(sleep_req)) else $error("sleep moved");
	a_rsvd_inert: assert property ((sleep_req & ~M) == 0) else $error("reserved set");
	a_sts_mirror: assert property (rd && avs_address == 4'hC && $past(clk_req_in, 4) == clk_req_in && !$past(srst, 4) |-> avs_readdata == (clk_req_in & M & ~32'h2)) else $error("status");
	a_en_readback: assert property (rd && avs_address == 4'h8 |-> avs_readdata == sleep_req) else $error("readback");
	a_unmapped_zero: assert property (rd && avs_address != 4'h8 && avs_address != 4'hC |-> avs_readdata == 0) else $error("unmapped");
	a_reset_clear: assert property ($fell(srst) |-> sleep_req == 0 && !all_asleep) else $error("reset");
	a_asleep_qual: assert property (all_asleep |-> sleep_req == M || $past(sleep_req) == M) else $error("asleep");
	c_write: cover property (wr && avs_address == 4'h8);
	c_status: cover property (rd && avs_address == 4'hC);
	c_asleep: cover property (all_asleep);
endmodule // csr_chk
bind csr_sleep_ctrl csr_chk i_csr_chk (.*);
`default_nettype wire

// [csr_periph_model.sv]
`timescale 1ns/1ps
`default_nettype none
module csr_periph_model (
	// clock
	input wire logic clk,
	// sleep handshake
	input wire logic [31:0] sleep_req, busy, hold,
	output logic [31:0] clk_req
);
	// sleeping blocks drop their request; held bits model auto-reload counters and accesses
	always @(posedge clk)
		clk_req <= hold | (busy & ~sleep_req);
endmodule // csr_periph_model
`default_nettype wire

// [csr_sleep_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.vh"
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t mismatch %h vs %h", $time, a, b); end end
module csr_sleep_ctrl_tb_top;
	localparam M = `CSR_IMPL_MASK;
	logic clk = 0, srst = 1, rdq = 0, wrq = 0;
	logic [3:0] adr = 0, be = 4'hF;
	logic [31:0] wd = 0, busy = 32'h100, hold = 0, got;
	wire [31:0] rdata, sreq, creq;
	wire wait_r, asleep;
	int fail_count = 0, total_checks = 0;
	csr_sleep_ctrl i_csr_sleep_ctrl (.clk(clk), .srst(srst), .avs_address(adr), .avs_read(rdq), .avs_write(wrq),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_r),
		.sleep_req(sreq), .clk_req_in(creq), .all_asleep(asleep));
	csr_periph_model i_csr_periph_model (.clk(clk), .sleep_req(sreq), .busy(busy), .hold(hold), .clk_req(creq));
	initial forever #20 clk = ~clk;
	task results;
		$display("checks %0d fails %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one bus transfer, held until waitrequest is seen low
	task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		wd <= d;
		wrq <= w;
		rdq <= !w;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wait_r !== 1'b0 && n < 9);
		got = rdata;
		wrq <= 0;
		rdq <= 0;
		if (n >= 9)
		begin
			fail_count++;
			results;
		end
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		xfer(0, a, 0);
		`CHK(got, e)
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 0;
		rd(4'h8, 0);
		rd(4'hC, 32'h100);
		for (int i = 0; i < 32; i++)
		begin
			xfer(1, 4'h8, 32'h1 << i);
			rd(4'h8, (32'h1 << i) & M);
			`CHK(sreq, (32'h1 << i) & M)
		end
		xfer(1, 4'h8, 0);
		busy <= 32'hFFFFFFFF;
		repeat (5) @(posedge clk);
		rd(4'hC, M & ~32'h2);
		`CHK(sreq, 32'h0)
		be <= 4'h1;
		xfer(1, 4'h8, 32'hFFFFFFFF);
		be <= 4'hF;
		rd(4'h8, 32'hF7);
		hold <= 32'hC0000000;
		xfer(1, 4'h8, M);
		repeat (5) @(posedge clk);
		rd(4'hC, 32'hC0000000);
		`CHK(asleep, 1'b0)
		hold <= 0;
		repeat (5) @(posedge clk);
		`CHK(asleep, 1'b1)
		xfer(1, 4'hC, 0);
		rd(4'h8, M);
		rd(4'h4, 0);
		srst <= 1;
		repeat (3) @(posedge clk);
		srst <= 0;
		rd(4'h8, 0);
		results;
	end
endmodule // csr_sleep_ctrl_tb_top
`default_nettype wire
